// ==== core/fsk_tx_power_and_freq_trim.sv ====
`timescale 1ns/100ps
`default_nettype none

module fsk_tx_power_and_freq_trim #(
  parameter int BIT_DIV = 10000,      // clocks per transmitted bit
  parameter int FIFO_D  = 4           // bit buffer depth
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // shared data pin, split into three signals
  input  wire logic        shared_data_pin_i,
  output logic             shared_data_pin_o,
  output logic             shared_data_pin_oe,
  output logic             data_strobe_pin,
  // receive and measurement side
  input  wire logic        rx_data,
  input  wire logic        fee_up_pulse,
  input  wire logic        fee_dn_pulse,
  input  wire logic        symbol_tick,
  input  wire logic        synth_lock,
  // radio controls
  output logic      [2:0]  tx_power_level,
  output logic             pa_enable,
  output logic             low_noise_amp_bypass,
  output logic             sync_enable,
  output logic             operating_mode_hi,
  output logic             operating_mode_lo,
  output logic             signal_strength_enable,
  output logic             lock_detect_enable,
  output logic             prefilter_cutoff_hi,
  output logic             prefilter_cutoff_lo,
  output logic      [7:0]  synth_m,
  output logic      [7:0]  synth_n,
  output logic      [7:0]  synth_a,
  output logic             tx_bit_active
);

  localparam int DW = fsk_tx_pkg::DIV_W;
  localparam int CW = 16;

  // ---------------- register state ----------------
  logic [7:0]  tx_ctrl_q;             // power, mode and bypass bits
  logic [3:0]  ind_q;                 // indicator and prefilter bits
  logic [3:0]  fe_ctl_q;              // measurement control
  logic [23:0] div_zero_q;            // divider set for bit zero
  logic [23:0] div_one_q;             // divider set for bit one
  logic        overrun_q;             // sampled bit lost, sticky
  logic [31:0] prdata_q;              // read data captured at setup

  // ---------------- datapath state ----------------
  logic [CW-1:0] div_cnt_q;           // bit rate divider
  logic          bit_tick_q;          // one-cycle bit boundary pulse
  logic          pin_sync1_q;         // first synchroniser stage
  logic          pin_sync2_q;         // second synchroniser stage
  logic          pend_q;              // sampled bit waiting for buffer
  logic          pend_bit_q;          // value of the waiting bit
  logic          strobe_q;            // bit strobe toward host
  logic          rx_out_q;            // receive data toward pin
  logic [DW-1:0] m_q;                 // active m divider
  logic [DW-1:0] n_q;                 // active n divider
  logic [DW-1:0] a_q;                 // active a divider
  logic          bit_q;               // bit currently modulated

  // ---------------- bus decode ----------------
  wire [6:0]  idx;
  wire        upper_zero;
  wire        setup;
  wire        access;
  wire        wr;
  wire        hit_tx;
  wire        hit_ind;
  wire        hit_fe_ctl;
  wire        hit_fe_cnt;
  wire        hit_status;
  wire        hit_div0;
  wire        hit_div1;
  wire        hit_any;
  wire        lane0;
  wire        lane1;
  wire        lane2;
  wire [7:0]  rd_tx;
  wire [7:0]  rd_ind;
  wire [7:0]  rd_status;
  wire [31:0] rd_mux;

  // ---------------- block wires ----------------
  wire        tx_mode;
  wire [7:0]  fe_count;
  wire        fe_busy;
  wire        fe_done;
  wire        fe_start;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_out_bit;
  wire        drain;
  wire        capture;
  wire        lost;
  wire        div_wrap;
  wire [23:0] div_sel;

  // word index from byte address, upper bits must be zero
  assign idx        = paddr[8:2];
  assign upper_zero = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);
  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  assign wr         = access & pwrite;
  assign lane0      = pstrb[0];
  assign lane1      = pstrb[1];
  assign lane2      = pstrb[2];

  // one hit per mapped register
  assign hit_tx     = upper_zero && (idx == fsk_tx_pkg::IDX_TX_CTRL);
  assign hit_ind    = upper_zero && (idx == fsk_tx_pkg::IDX_IND_CTRL);
  assign hit_fe_ctl = upper_zero && (idx == fsk_tx_pkg::IDX_FE_CTL);
  assign hit_fe_cnt = upper_zero && (idx == fsk_tx_pkg::IDX_FE_COUNT);
  assign hit_status = upper_zero && (idx == fsk_tx_pkg::IDX_STATUS);
  assign hit_div0   = upper_zero && (idx == fsk_tx_pkg::IDX_DIV_ZERO);
  assign hit_div1   = upper_zero && (idx == fsk_tx_pkg::IDX_DIV_ONE);
  assign hit_any    = hit_tx | hit_ind | hit_fe_ctl | hit_fe_cnt
                    | hit_status | hit_div0 | hit_div1;

  // read-back values with fixed bits folded in
  assign rd_tx      = tx_ctrl_q | fsk_tx_pkg::TX_CTRL_FIX;
  assign rd_ind     = fsk_tx_pkg::IND_FIX | {4'h0, ind_q};
  assign rd_status  = {5'h00, overrun_q, fe_done, fe_busy};

  // read selection, unmapped reads give zero
  assign rd_mux = hit_tx     ? {24'h000000, rd_tx}          :
                  hit_ind    ? {24'h000000, rd_ind}         :
                  hit_fe_ctl ? {28'h0000000, fe_ctl_q}      :
                  hit_fe_cnt ? {24'h000000, fe_count}       :
                  hit_status ? {24'h000000, rd_status}      :
                  hit_div0   ? {8'h00, div_zero_q}          :
                  hit_div1   ? {8'h00, div_one_q}           :
                               32'h00000000;

  // zero-wait slave, error only for unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata  = prdata_q;

  // read data captured in setup, stable through access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // control register writes on the access edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ctrl_q <= fsk_tx_pkg::TX_CTRL_RST;
      ind_q     <= fsk_tx_pkg::IND_RST;
      fe_ctl_q  <= 4'h0;
    end else if (wr & lane0) begin
      if (hit_tx)     tx_ctrl_q <= pwdata[7:0];
      if (hit_ind)    ind_q     <= pwdata[fsk_tx_pkg::IND_HI:0];
      if (hit_fe_ctl) fe_ctl_q  <= pwdata[3:0];
    end
  end

  // divider set registers, byte lanes honoured
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_zero_q <= 24'h000000;
      div_one_q  <= 24'h000000;
    end else if (wr) begin
      if (hit_div0 & lane0) div_zero_q[7:0]   <= pwdata[7:0];
      if (hit_div0 & lane1) div_zero_q[15:8]  <= pwdata[15:8];
      if (hit_div0 & lane2) div_zero_q[23:16] <= pwdata[23:16];
      if (hit_div1 & lane0) div_one_q[7:0]    <= pwdata[7:0];
      if (hit_div1 & lane1) div_one_q[15:8]   <= pwdata[15:8];
      if (hit_div1 & lane2) div_one_q[23:16]  <= pwdata[23:16];
    end
  end

  // a write of the control register starts a measurement
  assign fe_start = wr & lane0 & hit_fe_ctl;

  // ---------------- radio control outputs ----------------
  assign tx_power_level = tx_ctrl_q[fsk_tx_pkg::PWR_HI:fsk_tx_pkg::PWR_LO];
  // amplifier off only for the zero code
  assign pa_enable      = (tx_power_level != fsk_tx_pkg::PWR_OFF);
  assign low_noise_amp_bypass   = tx_ctrl_q[fsk_tx_pkg::LNA_BIT];
  assign sync_enable            = tx_ctrl_q[fsk_tx_pkg::SYNC_BIT];
  assign operating_mode_hi      = tx_ctrl_q[fsk_tx_pkg::MODE_HI];
  assign operating_mode_lo      = tx_ctrl_q[fsk_tx_pkg::MODE_LO];
  assign signal_strength_enable = ind_q[fsk_tx_pkg::SSI_BIT];
  assign lock_detect_enable     = ind_q[fsk_tx_pkg::LDE_BIT];
  assign prefilter_cutoff_hi    = ind_q[fsk_tx_pkg::PFC_HI];
  assign prefilter_cutoff_lo    = ind_q[fsk_tx_pkg::PFC_LO];
  assign tx_mode = ({operating_mode_hi, operating_mode_lo}
                    == fsk_tx_pkg::MODE_TX);

  // ---------------- shared pin direction ----------------
  // host drives the pin in transmit, we drive it otherwise
  assign shared_data_pin_oe = ~tx_mode;
  assign shared_data_pin_o  = rx_out_q;
  assign data_strobe_pin    = strobe_q;

  // receive data retimed before reaching the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rx_out_q <= 1'b0;
    else     rx_out_q <= rx_data;
  end

  // two-stage synchroniser on the host-driven pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync1_q <= 1'b0;
      pin_sync2_q <= 1'b0;
    end else begin
      pin_sync1_q <= shared_data_pin_i;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // ---------------- bit rate divider ----------------
  assign div_wrap = (div_cnt_q == CW'(BIT_DIV - 1));

  // free count in transmit, held at zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q  <= '0;
      bit_tick_q <= 1'b0;
    end else begin
      div_cnt_q  <= (~tx_mode | div_wrap) ? '0 : div_cnt_q + 1'b1;
      bit_tick_q <= tx_mode & div_wrap;
    end
  end

  // strobe tells the host a bit boundary passed, whether or not the bit was taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) strobe_q <= 1'b0;
    else     strobe_q <= bit_tick_q & tx_mode;   // no strobe after leaving tx
  end

  // ---------------- sampler with back-pressure ----------------
  // a new sample is taken only when the previous one is gone
  assign capture = bit_tick_q & (~pend_q | fifo_in_ready);
  assign lost    = bit_tick_q & pend_q & ~fifo_in_ready;

  // holds one bit until the buffer accepts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q     <= 1'b0;
      pend_bit_q <= 1'b0;
    end else if (~tx_mode) begin
      pend_q     <= 1'b0;
    end else if (capture) begin
      pend_q     <= 1'b1;
      pend_bit_q <= pin_sync2_q;
    end else if (fifo_in_ready) begin
      pend_q     <= 1'b0;
    end
  end

  // overrun sticky, set wins over a write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (lost) begin
      overrun_q <= 1'b1;
    end else if (wr & lane0 & hit_status & pwdata[fsk_tx_pkg::ST_OVERRUN]) begin
      overrun_q <= 1'b0;
    end
  end

  // buffer between pin sampling and modulation
  bit_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_bit_q),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_bit)
  );

  // modulation drains one bit per boundary while locked
  assign drain = tx_mode & bit_tick_q & synth_lock;

  // ---------------- divider set selection ----------------
  assign div_sel = fifo_out_bit ? div_one_q : div_zero_q;

  // whole set loaded in one edge, so no mixed values appear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_q   <= '0;
      n_q   <= '0;
      a_q   <= '0;
      bit_q <= 1'b0;
    end else if (~tx_mode) begin
      // receive uses set zero as local oscillator
      m_q   <= div_zero_q[fsk_tx_pkg::DIV_M_LO +: DW];
      n_q   <= div_zero_q[fsk_tx_pkg::DIV_N_LO +: DW];
      a_q   <= div_zero_q[fsk_tx_pkg::DIV_A_LO +: DW];
      bit_q <= 1'b0;
    end else if (drain & fifo_out_valid) begin
      m_q   <= div_sel[fsk_tx_pkg::DIV_M_LO +: DW];
      n_q   <= div_sel[fsk_tx_pkg::DIV_N_LO +: DW];
      a_q   <= div_sel[fsk_tx_pkg::DIV_A_LO +: DW];
      bit_q <= fifo_out_bit;
    end
  end

  assign synth_m       = m_q;
  assign synth_n       = n_q;
  assign synth_a       = a_q;
  assign tx_bit_active = bit_q;

  // ---------------- frequency error measurement ----------------
  freq_err_counter #(
    .W (8)
  ) u_fe (
    .clk         (clk),
    .rst         (rst),
    .start       (fe_start),
    .ctl         (pwdata[3:0]),
    .symbol_tick (symbol_tick),
    .up_pulse    (fee_up_pulse),
    .dn_pulse    (fee_dn_pulse),
    .count       (fe_count),
    .busy        (fe_busy),
    .done        (fe_done)
  );

endmodule : fsk_tx_power_and_freq_trim

`default_nettype wire

// ==== core/fsk_tx_pkg.sv ====
package fsk_tx_pkg;

  // register index width and bus address width
  localparam int          IDX_W        = 7;
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          REG_W        = 8;

  // register indices, byte address is four times the index
  localparam logic [6:0]  IDX_TX_CTRL  = 7'h00;
  localparam logic [6:0]  IDX_IND_CTRL = 7'h01;
  localparam logic [6:0]  IDX_FE_CTL   = 7'h15;
  localparam logic [6:0]  IDX_FE_COUNT = 7'h16;
  localparam logic [6:0]  IDX_STATUS   = 7'h17;
  localparam logic [6:0]  IDX_DIV_ZERO = 7'h20;
  localparam logic [6:0]  IDX_DIV_ONE  = 7'h21;

  // transmit control field positions
  localparam int          LNA_BIT      = 7;
  localparam int          PWR_HI       = 6;
  localparam int          PWR_LO       = 4;
  localparam int          SYNC_BIT     = 3;
  localparam int          MODE_HI      = 2;
  localparam int          MODE_LO      = 1;

  // indicator control field positions
  localparam int          IND_HI       = 3;
  localparam int          SSI_BIT      = 3;
  localparam int          LDE_BIT      = 2;
  localparam int          PFC_HI       = 1;
  localparam int          PFC_LO       = 0;

  // fixed read-back bits
  localparam logic [7:0]  TX_CTRL_FIX  = 8'h01;
  localparam logic [7:0]  IND_FIX      = 8'h80;

  // reset values, amplifier off, receive mode
  localparam logic [7:0]  TX_CTRL_RST  = 8'h02;
  localparam logic [3:0]  IND_RST      = 4'h0;
  localparam logic [2:0]  PWR_OFF      = 3'h0;

  // operating mode codes
  localparam logic [1:0]  MODE_TX      = 2'h2;

  // frequency error control fields and mode codes
  localparam int          FE_MODE_HI   = 1;
  localparam int          FE_MODE_LO   = 0;
  localparam int          FE_LEN_HI    = 3;
  localparam int          FE_LEN_LO    = 2;
  localparam logic [1:0]  FE_OFF       = 2'h0;
  localparam logic [1:0]  FE_UP        = 2'h1;
  localparam logic [1:0]  FE_DN        = 2'h2;
  localparam logic [1:0]  FE_UPDN      = 2'h3;
  localparam logic [6:0]  FE_SYM_BASE  = 7'h08;

  // status bit positions
  localparam int          ST_BUSY      = 0;
  localparam int          ST_DONE      = 1;
  localparam int          ST_OVERRUN   = 2;

  // divider word fields
  localparam int          DIV_W        = 8;
  localparam int          DIV_M_LO     = 0;
  localparam int          DIV_N_LO     = 8;
  localparam int          DIV_A_LO     = 16;

  // measurement sequencer states
  typedef enum logic [2:0] {
    FE_IDLE = 3'b001,
    FE_RUN  = 3'b010,
    FE_DONE = 3'b100
  } fe_state_t;

endpackage : fsk_tx_pkg

// ==== core/bit_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none

module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];      // storage words
  logic [AW:0]      wr_q;             // write pointer with wrap bit
  logic [AW:0]      rd_q;             // read pointer with wrap bit
  wire              full;
  wire              empty;
  wire              push;
  wire              pop;

  // full when pointers differ only in wrap bit
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty     = (wr_q == rd_q);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  // pointer update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end

endmodule : bit_fifo

`default_nettype wire

// ==== core/freq_err_counter.sv ====
`timescale 1ns/100ps
`default_nettype none

module freq_err_counter #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [3:0]   ctl,
  input  wire logic         symbol_tick,
  input  wire logic         up_pulse,
  input  wire logic         dn_pulse,
  output logic      [W-1:0] count,
  output logic              busy,
  output logic              done
);

  fsk_tx_pkg::fe_state_t state_q;     // sequencer state
  logic [1:0]            mode_q;      // latched counting mode
  logic [6:0]            target_q;    // symbols to count
  logic [6:0]            sym_q;       // symbols seen
  wire                   up_en;
  wire                   dn_en;
  wire  [W-1:0]          count_d;

  // up counts only in modes with low bit set, down with high bit
  assign up_en   = up_pulse & mode_q[fsk_tx_pkg::FE_MODE_LO];
  assign dn_en   = dn_pulse & mode_q[fsk_tx_pkg::FE_MODE_HI];
  // plain modulo arithmetic, no saturation at either limit
  assign count_d = count + W'(up_en) - W'(dn_en);
  assign busy    = (state_q == fsk_tx_pkg::FE_RUN);
  assign done    = (state_q == fsk_tx_pkg::FE_DONE);

  // measurement sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= fsk_tx_pkg::FE_IDLE;
      mode_q   <= fsk_tx_pkg::FE_OFF;
      target_q <= fsk_tx_pkg::FE_SYM_BASE;
      sym_q    <= '0;
      count    <= '0;
    end else if (start) begin
      mode_q   <= ctl[fsk_tx_pkg::FE_MODE_HI:fsk_tx_pkg::FE_MODE_LO];
      target_q <= fsk_tx_pkg::FE_SYM_BASE
                  << ctl[fsk_tx_pkg::FE_LEN_HI:fsk_tx_pkg::FE_LEN_LO];
      sym_q    <= '0;
      count    <= '0;
      // off mode leaves the sequencer idle
      state_q  <= (ctl[fsk_tx_pkg::FE_MODE_HI:fsk_tx_pkg::FE_MODE_LO]
                   == fsk_tx_pkg::FE_OFF) ? fsk_tx_pkg::FE_IDLE
                                          : fsk_tx_pkg::FE_RUN;
    end else begin
      case (state_q)
        fsk_tx_pkg::FE_RUN: begin
          count <= count_d;
          if (symbol_tick) begin
            sym_q <= sym_q + 1'b1;
            // window closes on the last counted symbol
            if (sym_q + 1'b1 == target_q) state_q <= fsk_tx_pkg::FE_DONE;
          end
        end
        fsk_tx_pkg::FE_IDLE: state_q <= fsk_tx_pkg::FE_IDLE;
        fsk_tx_pkg::FE_DONE: state_q <= fsk_tx_pkg::FE_DONE;
        default:             state_q <= fsk_tx_pkg::FE_IDLE;
      endcase
    end
  end

endmodule : freq_err_counter

`default_nettype wire

// ==== testbench/fsk_tx_props.sv ====
`timescale 1ns/100ps
`default_nettype none

module fsk_tx_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rx_data,
  input wire logic       shared_data_pin_o,
  input wire logic       shared_data_pin_oe,
  input wire logic       data_strobe_pin,
  input wire logic [2:0] tx_power_level,
  input wire logic       pa_enable,
  input wire logic       operating_mode_hi,
  input wire logic       operating_mode_lo,
  input wire logic [7:0] synth_m,
  input wire logic [7:0] synth_n,
  input wire logic [7:0] synth_a,
  input wire logic       tx_bit_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // transmit mode decode
  wire tx = operating_mode_hi & ~operating_mode_lo;
  a_pa_off_code: assert property (pa_enable == (tx_power_level != 3'h0))
    else $error("amplifier enable disagrees with level");
  a_pin_dir: assert property (shared_data_pin_oe == !tx)
    else $error("data pin direction wrong for mode");
  a_rx_echo: assert property (shared_data_pin_oe && $past(shared_data_pin_oe)
    |-> shared_data_pin_o == $past(rx_data))
    else $error("receive data not echoed on pin");
  a_strobe_once: assert property (data_strobe_pin |=> !data_strobe_pin)
    else $error("strobe longer than one cycle");
  a_div_steady: assert property (tx && $past(tx) && !data_strobe_pin
    |-> $stable({synth_a, synth_n, synth_m}))
    else $error("dividers moved between bit boundaries");
  a_bit_idle: assert property (shared_data_pin_oe && $past(shared_data_pin_oe)
    |-> !tx_bit_active)
    else $error("bit active outside transmit");
  a_strobe_tx: assert property (data_strobe_pin |-> !$past(shared_data_pin_oe))
    else $error("strobe outside transmit");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("access without ready");
endmodule : fsk_tx_props

bind fsk_tx_power_and_freq_trim fsk_tx_props fsk_tx_props_i (.*);

`default_nettype wire

// ==== testbench/host_mcu.sv ====
`timescale 1ns/100ps
`default_nettype none

module host_mcu (
  input  wire logic dev_oe,
  input  wire logic level,
  output logic      host_o,
  output logic      host_oe
);
  // host drives the pin only while the device listens
  assign host_oe = ~dev_oe;
  // released pin shows the inverse so stale data cannot pass
  assign host_o  = host_oe ? level : ~level;
endmodule : host_mcu

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int BD = 8;            // shortened bit length
  logic        clk = 0, rst = 1;
  logic [11:0] paddr = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, pin_o, pin_oe, strobe;
  logic        rx_data = 0, up = 0, dn = 0, tick = 0, lock = 1;
  logic        level = 0, host_o, host_oe, pa_en, bit_act;
  logic [2:0]  pwr;
  logic [7:0]  sm, sn, sa;
  wire         pin = pin_oe ? pin_o : host_o;   // resolved wire
  logic        lna, syn, mhi, mlo, ssi, lde, pfh, pfl;
  int          errors = 0, samples_checked = 0, trim = 0;

  // free running clock
  always #2.5 clk = ~clk;

  fsk_tx_power_and_freq_trim #(.BIT_DIV(BD), .FIFO_D(4))
    fsk_tx_power_and_freq_trim_i (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shared_data_pin_i(pin),
    .shared_data_pin_o(pin_o), .shared_data_pin_oe(pin_oe),
    .data_strobe_pin(strobe), .rx_data(rx_data), .fee_up_pulse(up),
    .fee_dn_pulse(dn), .symbol_tick(tick), .synth_lock(lock),
    .tx_power_level(pwr), .pa_enable(pa_en), .low_noise_amp_bypass(lna),
    .sync_enable(syn), .operating_mode_hi(mhi), .operating_mode_lo(mlo),
    .signal_strength_enable(ssi), .lock_detect_enable(lde),
    .prefilter_cutoff_hi(pfh), .prefilter_cutoff_lo(pfl), .synth_m(sm),
    .synth_n(sn), .synth_a(sa), .tx_bit_active(bit_act));

  host_mcu host_mcu_i (.dev_oe(pin_oe), .level(level), .host_o(host_o),
    .host_oe(host_oe));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  // one apb transfer, waits for ready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // let the access edge's register updates settle before callers look
    @(posedge clk);
  endtask : apb

  task automatic reset_regs();
    check("pa_en", pa_en, 0);
    check("oe", pin_oe, 1);
    apb(0, 12'h000, 0);
    check("reg0", rd, 32'h03);
    apb(0, 12'h004, 0);
    check("reg1", rd, 32'h80);
    apb(1, 12'h004, 32'h0f);
    check("ind_pins", {ssi, lde, pfh, pfl}, 4'hf);
    apb(1, 12'h000, 32'h8a);
    check("ctl_pins", {lna, syn, mhi, mlo}, 4'hd);
    rx_data <= 1;
    repeat (3) @(posedge clk);
    check("pin", pin, 1);
  endtask : reset_regs

  task automatic power_levels();
    for (int c = 0; c < 8; c++) begin
      apb(1, 12'h000, {25'h0, c[2:0], 4'h2});
      check("pwr", pwr, c);
      check("pa_en", pa_en, c != 0);
      apb(0, 12'h000, 0);
      check("reg0", rd, {25'h0, c[2:0], 4'h3});
    end
    apb(0, 12'h0f0, 0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
  endtask : power_levels

  task automatic fsk_bits();
    apb(1, 12'h080, 32'h00332211);
    apb(1, 12'h084, 32'h00665544);
    apb(1, 12'h000, 32'h14);
    check("oe_tx", pin_oe, 0);
    for (int i = 0; i < 3; i++) begin
      level <= ~i[0];
      repeat (6 * BD) @(posedge clk);
      check("bit", bit_act, !i[0]);
      check("div", {sa, sn, sm}, i[0] ? 24'h332211 : 24'h665544);
    end
    // far side stalls, buffer fills and refuses
    lock <= 0;
    repeat (8 * BD) @(posedge clk);
    apb(0, 12'h05c, 0);
    check("overrun", rd[2], 1);
    apb(1, 12'h000, 32'h02);
    lock <= 1;
    apb(1, 12'h05c, 32'h04);
    apb(0, 12'h05c, 0);
    check("ovr_clr", rd[2], 0);
    check("div_rx", {sa, sn, sm}, 24'h332211);
  endtask : fsk_bits

  // one measurement: pulses, symbol ticks, then result
  task automatic fee(logic [3:0] ctl, int nu, int nd, int ns, logic [7:0] x);
    apb(1, 12'h054, {28'h0, ctl});
    for (int i = 0; i < nu || i < nd; i++) begin
      @(posedge clk);
      up <= i < nu;
      dn <= i < nd;
    end
    @(posedge clk);
    up <= 0;
    dn <= 0;
    repeat (ns) begin
      @(posedge clk);
      tick <= 1;
      @(posedge clk);
      tick <= 0;
    end
    repeat (2) @(posedge clk);
    apb(0, 12'h058, 0);
    check("count", rd[7:0], x);
    // host lowers the crystal trim on a positive error, raises on negative
    trim += ($signed(rd[7:0]) < 0) - ($signed(rd[7:0]) > 0);
    apb(0, 12'h05c, 0);
    check("done", rd[1], 1);
  endtask : fee

  task automatic final_report();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    reset_regs();
    power_levels();
    fsk_bits();
    fee(4'h2, 0, 129, 8, 8'h7f);
    fee(4'h2, 0, 131, 8, 8'h7d);
    fee(4'h1, 3, 5, 8, 8'h03);
    fee(4'h3, 2, 5, 8, 8'hfd);
    fee(4'h7, 128, 0, 16, 8'h80);
    check("trim", trim, -1);
    final_report();
  end
endmodule : testbench

`default_nettype wire
